// [fpes_pkg.sv]
// Constants, register map and types for the flash program/erase sequencer.
// Assumes an AHB-Lite slave front end with 32-bit data and a 200 MHz clock.
`default_nettype none
package fpes_pkg;
  // ==========================================================
  // Register map (byte addresses, chosen)
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] KEY_ADDR    = 8'h04;
  localparam logic [7:0] ADDRU_ADDR  = 8'h08;
  localparam logic [7:0] ADDRL_ADDR  = 8'h0c;
  // ==========================================================
  // Control field positions
  localparam int START_BIT  = 15;
  localparam int PROG_ENABLE_BIT   = 14;
  localparam int ERR_BIT    = 13;
  localparam int IDLE_BIT   = 12;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  // ==========================================================
  // Unlock keys
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // ==========================================================
  // Operation codes
  typedef enum logic [3:0] {
    OP_DWORD = 4'h1,
    OP_ROW   = 4'h2,
    OP_PAGE  = 4'h3,
    OP_UNUSED= 4'h4,
    OP_CHIP  = 4'he
  } fpes_op_t;
  // ==========================================================
  // Self-timed durations in microseconds, and cycles at 200 MHz
  localparam int CLK_MHZ      = 200;
  localparam int T_DWORD_US   = 20;
  localparam int T_ROW_US     = 1500;
  localparam int T_PAGE_US    = 20000;
  localparam int T_CHIP_US    = 40000;
  localparam int CYC_DWORD    = T_DWORD_US * CLK_MHZ;
  localparam int CYC_ROW      = T_ROW_US * CLK_MHZ;
  localparam int CYC_PAGE     = T_PAGE_US * CLK_MHZ;
  localparam int CYC_CHIP     = T_CHIP_US * CLK_MHZ;
  localparam int ROW_INSTR    = 128;
  localparam int BLOCK_INSTR  = 1024;
  // ==========================================================
  // Key tracker and sequencer states
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_HALF = 2'b01,
    KEY_OPEN = 2'b10
  } fpes_key_t;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_BUSY = 2'b01,
    SEQ_DONE = 2'b10
  } fpes_seq_t;
endpackage
`default_nettype wire

// [fpes_key_guard.sv]
// Unlock key tracker: opens for exactly one write after 55h then AAh.
// Assumes write strobes are one-cycle pulses from the bus slave.
`default_nettype none
module fpes_key_guard
  import fpes_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       clkEn,
  // Bus events
  input  wire logic       keyWr,
  input  wire logic [7:0] keyData,
  input  wire logic       anyWr,
  // Result
  output logic            unlocked
);
  typedef struct packed {
    fpes_key_t st;
  } fpes_kg_t;
  fpes_kg_t s_q, s_d;

  // ==========================================================
  // Any other write closes the window, so the keys must be immediate.
  always_comb begin
    s_d = s_q;
    if (keyWr) begin
      if (keyData == KEY_FIRST) begin
        s_d.st = KEY_HALF;
      end else if (keyData == KEY_SECOND && s_q.st == KEY_HALF) begin
        s_d.st = KEY_OPEN;
      end else begin
        s_d.st = KEY_IDLE;
      end
    end else if (anyWr) begin
      s_d.st = KEY_IDLE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{st: KEY_IDLE};
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  assign unlocked = (s_q.st == KEY_OPEN);
endmodule
`default_nettype wire

// [fpes_timer.sv]
// Self-timed operation counter; loads a length and pulses done once the count reaches one.
// Assumes load is a one-cycle pulse while not busy.
`default_nettype none
module fpes_timer #(
  parameter int W = 24
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         clkEn,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] len,
  input  wire logic         abort,
  // Status
  output logic              busy,
  output logic              done
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         busy;
    logic         done;
  } fpes_tm_t;
  fpes_tm_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (load) begin
      s_d.cnt  = len;
      s_d.busy = 1'b1;
    end else if (s_q.busy) begin
      if (abort) begin
        s_d.busy = 1'b0;
      end else if (s_q.cnt <= W'(1)) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign done = s_q.done;
endmodule
`default_nettype wire

// [fpes_top.sv]
// Flash program/erase sequencer with an AHB-Lite register slave.
// Assumes resetn is the power-on reset; sysResetn carries all other resets.
// The flash array answers only through flashAbort; operation lengths are self-timed here.
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`default_nettype none
module fpes_top
  import fpes_pkg::*;
#(
  parameter int TW        = 24,
  parameter int CYC_DW_P  = CYC_DWORD,
  parameter int CYC_ROW_P = CYC_ROW,
  parameter int CYC_PG_P  = CYC_PAGE,
  parameter int CYC_CH_P  = CYC_CHIP
) (
  // Clock, resets, enable
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        sysResetn,
  input  wire logic        clkEn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Core power state and flash termination
  input  wire logic        idleMode,
  input  wire logic        flashAbort,
  // Flash array and CPU
  output logic             cpuStall,
  output logic             flashOpValid,
  output logic [3:0]       flashOpCode,
  output logic [23:0]      flashAddr,
  output logic             flashUseAddr,
  output logic             flashPowerOff,
  output logic             flashStandby
);
  // ==========================================================
  // State
  typedef struct packed {
    logic        aWr;
    logic [7:0]  aAddr;
    logic        start;
    logic        prog_enable;
    logic        err;
    logic        idlePwr;
    logic [3:0]  opSel;
    logic [7:0]  addrU;
    logic [15:0] addrL;
    fpes_seq_t   seq;
    logic [31:0] rdata;
    logic        stall;
    logic        opValid;
    logic [3:0]  opCode;
    logic [23:0] fAddr;
    logic        useAddr;
    logic        pwrOff;
    logic        stby;
  } fpes_st_t;
  fpes_st_t s_q, s_d;

  logic          unlocked;
  logic          tBusy;
  logic          tDone;
  logic          tLoad;
  logic [TW-1:0] tLen;
  logic          wrPhase;
  logic          keyWr;

  // ==========================================================
  // Helpers
  function automatic logic op_valid(input logic [3:0] op);
    return op == OP_DWORD || op == OP_ROW || op == OP_PAGE || op == OP_CHIP;
  endfunction

  function automatic logic [TW-1:0] op_len(input logic [3:0] op);
    logic [TW-1:0] l;
    l = TW'(CYC_DW_P);
    unique case (op)
      OP_ROW:  l = TW'(CYC_ROW_P);
      OP_PAGE: l = TW'(CYC_PG_P);
      OP_CHIP: l = TW'(CYC_CH_P);
      default: l = TW'(CYC_DW_P);
    endcase
    return l;
  endfunction

  function automatic logic [31:0] ctrl_word(input fpes_st_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[START_BIT] = s.start;
    w[PROG_ENABLE_BIT]  = s.prog_enable;
    w[ERR_BIT]   = s.err;
    w[IDLE_BIT]  = s.idlePwr;
    w[3:0]       = s.opSel;
    return w;
  endfunction

  assign wrPhase = s_q.aWr;
  assign keyWr   = wrPhase && s_q.aAddr == KEY_ADDR;

  // ==========================================================
  // Sub-blocks
  fpes_key_guard u_key (
    .clk      (clk),
    .resetn   (resetn),
    .clkEn    (clkEn),
    .keyWr    (keyWr),
    .keyData  (hwdata[7:0]),
    .anyWr    (wrPhase),
    .unlocked (unlocked)
  );

  fpes_timer #(.W(TW)) u_tm (
    .clk    (clk),
    .resetn (resetn),
    .clkEn  (clkEn),
    .load   (tLoad),
    .len    (tLen),
    .abort  (flashAbort),
    .busy   (tBusy),
    .done   (tDone)
  );

  assign tLen = op_len(s_q.opSel);

  // ==========================================================
  // Next state
  always_comb begin
    s_d   = s_q;
    tLoad = 1'b0;
    s_d.aWr   = 1'b0;
    if (hsel && hready && htrans[1]) begin
      s_d.aWr   = hwrite;
      s_d.aAddr = haddr;
    end

    if (wrPhase) begin
      unique case (s_q.aAddr)
        CTRL_ADDR: begin
          s_d.prog_enable    = hwdata[PROG_ENABLE_BIT];
          s_d.idlePwr = hwdata[IDLE_BIT];
          if (s_q.seq == SEQ_IDLE) begin
            s_d.opSel = hwdata[3:0];
          end
          // Software cannot clear the start bit; only hardware does.
          if (hwdata[START_BIT] && s_q.seq == SEQ_IDLE) begin
            // Error flag is evaluated on every start attempt made while the sequencer is idle.
            if (unlocked && s_q.prog_enable && op_valid(s_q.opSel)) begin
              s_d.err   = 1'b0;
              s_d.start = 1'b1;
              s_d.seq   = SEQ_BUSY;
              s_d.stall = 1'b1;
              tLoad     = 1'b1;
              s_d.opValid = 1'b1;
              s_d.opCode  = s_q.opSel;
              s_d.fAddr   = {s_q.addrU, s_q.addrL};
              s_d.useAddr = s_q.opSel != OP_CHIP;
            end else begin
              s_d.err = 1'b1;
            end
          end
        end
        ADDRU_ADDR: begin
          if (s_q.seq == SEQ_IDLE) s_d.addrU = hwdata[7:0];
        end
        ADDRL_ADDR: begin
          if (s_q.seq == SEQ_IDLE) s_d.addrL = hwdata[15:0];
        end
        default: begin
        end
      endcase
    end

    if (s_q.seq == SEQ_BUSY) begin
      s_d.opValid = 1'b0;
      if (tDone || (!tBusy && !s_q.opValid)) begin
        // Abort leaves the timer idle without a done pulse.
        if (!tDone) s_d.err = 1'b1;
        s_d.seq = SEQ_DONE;
      end
    end else if (s_q.seq == SEQ_DONE) begin
      s_d.start = 1'b0;
      s_d.stall = 1'b0;
      s_d.seq   = SEQ_IDLE;
    end

    // Read data are taken from the next state, so a read whose address phase
    // shares an edge with a write's data phase already sees that write.
    if (hsel && hready && htrans[1]) begin
      unique case (haddr)
        CTRL_ADDR:  s_d.rdata = ctrl_word(s_d);
        ADDRU_ADDR: s_d.rdata = {24'h000000, s_d.addrU};
        ADDRL_ADDR: s_d.rdata = {16'h0000, s_d.addrL};
        default:    s_d.rdata = 32'h0000_0000;
      endcase
    end

    // Power-off needs an idle sequencer in the previous cycle, so it can overlap the first cycle of a launch.
    s_d.pwrOff = idleMode && s_q.idlePwr && s_q.seq == SEQ_IDLE;
    s_d.stby   = idleMode && !(s_q.idlePwr && s_q.seq == SEQ_IDLE);
  end

  // ==========================================================
  // Registers. Control bits follow the power-on reset only; the
  // system reset merely drops an in-flight bus access.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else if (clkEn) begin
      s_q <= s_d;
      if (!sysResetn) begin
        s_q.aWr <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    hrdata        = s_q.rdata;
    hreadyout     = 1'b1;
    hresp         = 1'b0;
    cpuStall      = s_q.stall;
    flashOpValid  = s_q.opValid;
    flashOpCode   = s_q.opCode;
    flashAddr     = s_q.fAddr;
    flashUseAddr  = s_q.useAddr;
    flashPowerOff = s_q.pwrOff;
    flashStandby  = s_q.stby;
  end

  logic unusedBits;
  assign unusedBits = ^{hsize, hwdata[31:16], hwdata[11:4]};
endmodule
`default_nettype wire

// [fpes_checker.sv]
// Port-level assertions for the flash program/erase sequencer.
// Bound into fpes_top; sees only its top-level ports.
`default_nettype none
module fpes_checker
  import fpes_pkg::*;
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hrdata,
  input wire logic        idleMode,
  input wire logic        cpuStall,
  input wire logic        flashOpValid,
  input wire logic [3:0]  flashOpCode,
  input wire logic        flashUseAddr,
  input wire logic        flashPowerOff,
  input wire logic        flashStandby
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rdTake;
  // The slave never waits, so a taken read is select plus a non-idle transfer.
  assign rdTake = hsel && htrans[1] && !hwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Properties
  a_launch_stall: assert property (flashOpValid |-> cpuStall)
    else $error("launch without stall");
  a_launch_pulse: assert property (flashOpValid |=> !flashOpValid)
    else $error("launch pulse too long");
  a_stall_end: assert property ($rose(cpuStall) |-> ##[1:40] !cpuStall)
    else $error("stall does not end");
  a_code_legal: assert property (flashOpValid |-> flashOpCode inside {4'h1, 4'h2, 4'h3, 4'he})
    else $error("undefined code launched");
  a_addr_use: assert property (flashOpValid |-> flashUseAddr == (flashOpCode != 4'he))
    else $error("address use wrong");
  a_power_mode: assert property ((flashPowerOff || flashStandby) |-> $past(idleMode) && !(flashPowerOff && flashStandby))
    else $error("power mode wrong");
  a_key_hidden: assert property ($past(rdTake && haddr == KEY_ADDR) |-> hrdata == 32'h0)
    else $error("key readable");
  a_ctrl_zeros: assert property ($past(rdTake && haddr == CTRL_ADDR) |-> hrdata[11:4] == 8'h00)
    else $error("unused bits not zero");
  c_chip: cover property (flashOpValid && flashOpCode == 4'he);
  c_done: cover property ($fell(cpuStall));
  c_off: cover property (flashPowerOff);
endmodule
bind fpes_top fpes_checker u_chk (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hrdata, .idleMode,
  .cpuStall, .flashOpValid, .flashOpCode, .flashUseAddr, .flashPowerOff, .flashStandby);
`default_nettype wire

// [fpes_flash_model.sv]
// Flash array stand-in: answers a launch, optionally with a termination.
// Assumes abortReq is set by the bench before the launch it should hit.
`default_nettype none
module fpes_flash_model (
  // Launch and control
  input wire logic  clk,
  input wire logic  flashOpValid,
  input wire logic  abortReq,
  // Answer
  output wire logic flashAbort
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt    = 3'h0;
  logic       abortQ = 1'b0;
  // ==========================================================
  // Termination
  // The pulse lands mid-operation so the sequencer sees it while busy.
  always @(posedge clk) begin
    if (flashOpValid && abortReq) cnt <= 3'h5;
    else if (cnt != 3'h0) cnt <= cnt - 3'h1;
    abortQ <= (cnt == 3'h3) || (cnt == 3'h2);
  end
  assign flashAbort = abortQ;
endmodule
`default_nettype wire

// [fpes_top_tb.sv]
// Self-checking bench for the flash program/erase sequencer.
// Assumes one AHB-Lite master here and the flash stand-in model.
`default_nettype none
module fpes_top_tb
  import fpes_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Bench
  logic        clk, resetn, sysResetn, hsel, hwrite, idleMode, abortReq, flashAbort, clkEn;
  logic        hreadyout, hresp, cpuStall, flashOpValid, flashUseAddr, flashPowerOff, flashStandby;
  logic [1:0]  htrans;
  logic [3:0]  flashOpCode;
  logic [7:0]  haddr;
  logic [23:0] flashAddr;
  logic [31:0] hwdata, hrdata, rd;
  int          nFail = 0, samplesChecked = 0, nLaunch = 0, stallCyc = 0;

  fpes_top #(.CYC_DW_P(8), .CYC_ROW_P(12), .CYC_PG_P(16), .CYC_CH_P(20)) dut (
    .clk, .resetn, .sysResetn, .clkEn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .idleMode, .flashAbort, .cpuStall, .flashOpValid,
    .flashOpCode, .flashAddr, .flashUseAddr, .flashPowerOff, .flashStandby);
  fpes_flash_model fm (.clk, .flashOpValid, .abortReq, .flashAbort);

  always @(posedge clk) begin
    if (flashOpValid === 1'b1) nLaunch <= nLaunch + 1;
    stallCyc <= (flashOpValid === 1'b1) ? 0 : stallCyc + int'(cpuStall === 1'b1);
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic print_verdict();
    if (nFail == 0 && samplesChecked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Values are read just after the edge, so they are the ones sampled at it.
  task automatic waitFor(input bit idle);
    for (int i = 0; i < 300; i++) begin
      @(posedge clk);
      if (idle ? cpuStall === 1'b0 : hreadyout === 1'b1) return;
    end
    nFail++;
    print_verdict();
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    {hsel, haddr, hwrite, htrans} <= {1'b1, a, w, 2'b10};
    waitFor(1'b0);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
    waitFor(1'b0);
    rd = hrdata;
  endtask
  task automatic launch(input logic [3:0] op, input logic we, input logic key);
    bus(CTRL_ADDR, 1'b1, {17'h0, we, 10'h0, op});
    if (key) begin
      bus(KEY_ADDR, 1'b1, 32'h55);
      bus(KEY_ADDR, 1'b1, 32'haa);
    end
    bus(CTRL_ADDR, 1'b1, {16'h0, 1'b1, we, 10'h0, op});
    repeat (2) @(posedge clk);
  endtask

  task automatic t_reset();
    bus(CTRL_ADDR, 1'b0, 32'h0);
    chk(rd, 32'h0);
    bus(CTRL_ADDR, 1'b1, 32'h3f0);
    bus(CTRL_ADDR, 1'b0, 32'h0);
    chk(rd, 32'h0);
    bus(KEY_ADDR, 1'b1, 32'h55);
    bus(KEY_ADDR, 1'b0, 32'h0);
    chk(rd, 32'h0);
    bus(8'h40, 1'b0, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_refuse();
    logic [5:0] cs [3] = '{6'h22, 6'h12, 6'h34};
    int n;
    n = nLaunch;
    foreach (cs[i]) begin
      launch(cs[i][3:0], cs[i][5], cs[i][4]);
      bus(CTRL_ADDR, 1'b0, 32'h0);
      chk(rd[15:13], {1'b0, cs[i][5], 1'b1});
    end
    bus(CTRL_ADDR, 1'b1, 32'h4002);
    bus(KEY_ADDR, 1'b1, 32'h55);
    bus(ADDRL_ADDR, 1'b1, 32'h0);
    bus(KEY_ADDR, 1'b1, 32'haa);
    bus(CTRL_ADDR, 1'b1, 32'hc002);
    bus(CTRL_ADDR, 1'b0, 32'h0);
    chk(rd[15:13], 3'b011);
    chk(nLaunch - n, 0);
  endtask
  task automatic t_ops();
    logic [3:0] ops [4] = '{4'h1, 4'h2, 4'h3, 4'he};
    int cyc [4] = '{8, 12, 16, 20};
    int n;
    bus(ADDRU_ADDR, 1'b1, 32'h12);
    bus(ADDRL_ADDR, 1'b1, 32'h3456);
    foreach (ops[i]) begin
      n = nLaunch;
      launch(ops[i], 1'b1, 1'b1);
      @(posedge clk);
      #1;
      chk(cpuStall, 1'b1);
      waitFor(1'b1);
      chk(nLaunch - n, 1);
      chk(flashOpCode, ops[i]);
      chk(flashUseAddr, i < 3);
      chk(stallCyc >= cyc[i], 1'b1);
      if (i < 3) chk(flashAddr, 24'h123456);
      bus(CTRL_ADDR, 1'b0, 32'h0);
      chk(rd[15:13], 3'b010);
    end
  endtask
  // Erase one block, then rewrite its eight rows one after another.
  task automatic t_block();
    int n;
    n = nLaunch;
    bus(ADDRU_ADDR, 1'b1, 32'h01);
    bus(ADDRL_ADDR, 1'b1, 32'h0);
    launch(OP_PAGE, 1'b1, 1'b1);
    waitFor(1'b1);
    for (int r = 0; r < BLOCK_INSTR / ROW_INSTR; r++) begin
      bus(ADDRL_ADDR, 1'b1, 32'(r * ROW_INSTR));
      launch(OP_ROW, 1'b1, 1'b1);
      waitFor(1'b1);
      chk(flashAddr, {8'h01, 16'(r * ROW_INSTR)});
    end
    chk(nLaunch - n, 1 + BLOCK_INSTR / ROW_INSTR);
  endtask
  // A low clock enable must hold a running operation and drop bus writes.
  task automatic t_freeze();
    launch(OP_DWORD, 1'b1, 1'b1);
    clkEn <= 1'b0;
    repeat (20) @(posedge clk);
    chk(cpuStall, 1'b1);
    clkEn <= 1'b1;
    waitFor(1'b1);
    clkEn <= 1'b0;
    bus(ADDRU_ADDR, 1'b1, 32'h77);
    clkEn <= 1'b1;
    bus(ADDRU_ADDR, 1'b0, 32'h0);
    chk(rd, 32'h01);
  endtask
  task automatic t_abort();
    abortReq <= 1'b1;
    launch(4'h1, 1'b1, 1'b1);
    repeat (2) @(posedge clk);
    waitFor(1'b1);
    abortReq <= 1'b0;
    sysResetn <= 1'b0;
    @(posedge clk);
    sysResetn <= 1'b1;
    bus(CTRL_ADDR, 1'b0, 32'h0);
    chk(rd[15:0], 16'h6001);
  endtask
  task automatic t_idle();
    bus(CTRL_ADDR, 1'b1, 32'h1000);
    idleMode <= 1'b1;
    repeat (3) @(posedge clk);
    chk({flashPowerOff, flashStandby}, 2'b10);
    bus(CTRL_ADDR, 1'b1, 32'h0);
    repeat (3) @(posedge clk);
    chk({flashPowerOff, flashStandby}, 2'b01);
    idleMode <= 1'b0;
  endtask

  initial begin
    {resetn, sysResetn, hsel, hwrite, idleMode, abortReq} = 6'b010000;
    {haddr, htrans, hwdata} = '0;
    clkEn = 1'b1;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_refuse();
    t_ops();
    t_block();
    t_abort();
    t_freeze();
    t_idle();
    print_verdict();
  end
endmodule
`default_nettype wire
